// *** hw/bmcc_pkg.sv ***
// Constants, field layout and state encoding for the board memory-cycle controller.
// Assumes a single 100 MHz system bus clock and an AHB-Lite slave port for setup.
package bmcc_pkg;

  // ==========================================================================
  // Widths
  localparam int ADDR_W  = 20;
  localparam int DATA_W  = 32;
  localparam int DADDR_W = 10;
  localparam int ROW_LSB = 10;

  // ==========================================================================
  // Register offsets (byte addresses on the bus)
  localparam logic [7:0] CFG_OFFSET    = 8'h00;
  localparam logic [7:0] STATUS_OFFSET = 8'h04;

  // ==========================================================================
  // Configuration field positions
  localparam int CFG_SRAM_WAIT_COUNT_LSB  = 0;
  localparam int CFG_CASRD_LSB  = 4;
  localparam int CFG_RASACC_LSB = 8;
  localparam int CFG_RASPRE_LSB = 12;
  localparam int CFG_HIT_BIT    = 16;
  localparam int CFG_EDO_BIT    = 17;

  // Status field positions.
  localparam int STAT_BUSY_BIT    = 0;
  localparam int STAT_RASHELD_BIT = 1;
  localparam int STAT_REFPEND_BIT = 2;

  // ==========================================================================
  // Reset values
  localparam logic [1:0] SRAM_WAIT_COUNT_RST  = 2'h3;
  localparam logic [1:0] CASRD_RST  = 2'h3;
  localparam logic [2:0] RASACC_RST = 3'h7;
  localparam logic [2:0] RASPRE_RST = 3'h7;
  localparam logic       HIT_RST    = 1'b0;
  localparam logic       EDO_RST    = 1'b0;

  // ==========================================================================
  // Timing counts in system clocks
  localparam logic [2:0] RAS_TO_CAS_CYC = 3'h2;
  localparam logic [2:0] WR_PULSE_CYC   = 3'h2;
  localparam logic [2:0] WR_RELEASE_CYC = 3'h2;

  // ==========================================================================
  // Controller states
  typedef enum logic [4:0] {
    ST_IDLE,
    ST_S_RACC,
    ST_S_RWAIT,
    ST_S_RDATA,
    ST_S_WACC,
    ST_S_WDATA,
    ST_S_WPULSE,
    ST_D_ROW,
    ST_D_RAS,
    ST_D_CAS,
    ST_D_CPRE,
    ST_D_WRAS,
    ST_D_WDATA,
    ST_D_WPULSE,
    ST_D_WEND,
    ST_HIT_CMP,
    ST_PRECH,
    ST_REF_CAS,
    ST_REF_RAS
  } bmcc_state_t;

endpackage

// *** hw/bmcc_ctrl.sv ***
// Board memory-cycle controller: processor block requests to SRAM and DRAM cycles.
// Assumes the processor interface logic runs on clk_i, and the refresh tick comes
// from an unrelated timer clock and is synchronised here.
//
// Notes on behaviour
// - SRAM read inserts zero to three wait cycles from the wait setting.
// - Each read word is latched and held, valid shows two clocks later.
// - SRAM address steps after each read word until the block's last word.
// - SRAM write accept comes one clock after the address is taken.
// - Each SRAM write word gets a two clock strobe, address then steps.
// - Write-done pulses in the cycle after the last SRAM word is written.
// - DRAM read raises RAS on the row, CAS follows two clocks later.
// - First read CAS lasts RAS access cycles plus one before data is taken.
// - DRAM reads repeat to the last word; page-hit mode keeps RAS asserted.
// - Extended-out mode takes read data one clock later, in CAS precharge.
// - Extended-out mode drives the DRAM write strobe in the final read cycle.
// - Parity for the check bus is computed between latch and valid.
// - DRAM writes are early writes; accept comes one clock after RAS.
// - Each DRAM write word gets a two clock CAS pulse, column then steps.
// - After the last DRAM write, RAS and strobe drop two clocks later; page-hit mode keeps RAS asserted.
// - A held-row read match goes straight to a CAS cycle.
// - A held-row write hit still delays accept one clock for the compare.
// - A held-row mismatch releases RAS, precharges, then runs a full access.
// - Refresh is CAS-before-RAS, triggered by the refresh timer tick.
// - A pending refresh ends any RAS hold.
// - CAS read time is the two-bit setting plus one clocks.
// - RAS access and precharge times are three-bit settings plus one clocks.
// - CAS precharge between read words is always one clock.
module bmcc_ctrl
  import bmcc_pkg::*;
(
  input  wire logic              clk_i,
  input  wire logic              rstn_i,
  // Processor side.
  input  wire logic              req_i,
  input  wire logic              req_write_i,
  input  wire logic              req_sram_i,
  input  wire logic [ADDR_W-1:0] addr_i,
  input  wire logic              wvalid_i,
  input  wire logic [DATA_W-1:0] wdata_i,
  input  wire logic              end_of_block_word_i,
  output logic                   transfer_accept_n_o,
  output logic                   read_word_valid_n_o,
  output logic [DATA_W-1:0]      rdata_o,
  output logic [3:0]             address_data_check_bus_o,
  output logic                   write_block_done_o,
  // SRAM side.
  output logic [ADDR_W-1:0]      sram_addr_o,
  output logic                   sram_oe_n_o,
  output logic                   sram_we_n_o,
  input  wire logic [DATA_W-1:0] sram_dq_i,
  output logic [DATA_W-1:0]      sram_dq_o,
  output logic                   sram_dq_oe_n_o,
  // DRAM side.
  output logic [DADDR_W-1:0]     dram_addr_o,
  output logic                   ras_n_o,
  output logic                   cas_n_o,
  output logic                   dram_we_n_o,
  input  wire logic [DATA_W-1:0] dram_dq_i,
  output logic [DATA_W-1:0]      dram_dq_o,
  output logic                   dram_dq_oe_n_o,
  // Refresh timer channel output.
  input  wire logic              refresh_tick_i,
  // AHB-Lite register port.
  input  wire logic              hsel_i,
  input  wire logic [31:0]       haddr_i,
  input  wire logic [1:0]        htrans_i,
  input  wire logic              hwrite_i,
  input  wire logic [2:0]        hsize_i,
  input  wire logic [31:0]       hwdata_i,
  input  wire logic              hready_i,
  output logic                   hreadyout_o,
  output logic                   hresp_o,
  output logic [31:0]            hrdata_o
);

  // ==========================================================================
  // State
  typedef struct packed {
    bmcc_state_t         st;
    logic [2:0]          cnt;
    logic [ADDR_W-1:0]   addr;
    logic [DADDR_W-1:0]  row;
    logic                is_wr;
    logic                last;
    logic                ras_held;
    logic [DATA_W-1:0]   rd0;
    logic [DATA_W-1:0]   rd1;
    logic [3:0]          par;
    logic [1:0]          vpipe;
    logic [DATA_W-1:0]   wd;
    logic                done;
    logic                rs1;
    logic                rs2;
    logic                rs3;
    logic                refr_pend;
    logic [1:0]          sram_wait_count;
    logic [1:0]          crd;
    logic [2:0]          racc;
    logic [2:0]          rpre;
    logic                hit_en;
    logic                edo;
    logic                ap_v;
    logic [7:0]          ap_addr;
    logic [31:0]         hrdata;
  } bmcc_regs_t;

  bmcc_regs_t q;
  bmcc_regs_t n;
  logic       rst_s1_q;
  logic       rst_n_q;
  logic       refr_edge;
  logic       row_match;
  logic       last_word;

  // ==========================================================================
  // Reset release
  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      rst_s1_q <= 1'b0;
      rst_n_q  <= 1'b0;
    end
    else
    begin
      rst_s1_q <= 1'b1;
      rst_n_q  <= rst_s1_q;
    end
  end

  // The edge detector reads only the second and third stages of the synchroniser.
  assign refr_edge = q.rs2 & ~q.rs3;
  assign row_match = (q.row == q.addr[ROW_LSB +: DADDR_W]);
  // In extended-out mode the word is taken in CAS precharge, so its end flag is live.
  assign last_word = q.edo ? end_of_block_word_i : q.last;

  // ==========================================================================
  // Next state
  always_comb
  begin
    logic [31:0] rv;
    rv = 32'h0;
    n  = q;
    n.done  = 1'b0;
    n.vpipe = {q.vpipe[0], 1'b0};
    if (q.vpipe[0])
    begin
      n.rd1 = q.rd0;
      n.par = {^q.rd0[31:24], ^q.rd0[23:16], ^q.rd0[15:8], ^q.rd0[7:0]};
    end
    n.rs1 = refresh_tick_i;
    n.rs2 = q.rs1;
    n.rs3 = q.rs2;

    // Register port: data-phase write, then address-phase capture.
    if (q.ap_v && q.ap_addr == CFG_OFFSET)
    begin
      n.sram_wait_count  = hwdata_i[CFG_SRAM_WAIT_COUNT_LSB +: 2];
      n.crd    = hwdata_i[CFG_CASRD_LSB +: 2];
      n.racc   = hwdata_i[CFG_RASACC_LSB +: 3];
      n.rpre   = hwdata_i[CFG_RASPRE_LSB +: 3];
      n.hit_en = hwdata_i[CFG_HIT_BIT];
      n.edo    = hwdata_i[CFG_EDO_BIT];
    end
    n.ap_v = 1'b0;
    if (hsel_i && htrans_i[1] && hready_i)
    begin
      n.ap_v    = hwrite_i;
      n.ap_addr = haddr_i[7:0];
      if (haddr_i[7:0] == CFG_OFFSET)
      begin
        rv[CFG_SRAM_WAIT_COUNT_LSB +: 2]  = q.sram_wait_count;
        rv[CFG_CASRD_LSB +: 2]  = q.crd;
        rv[CFG_RASACC_LSB +: 3] = q.racc;
        rv[CFG_RASPRE_LSB +: 3] = q.rpre;
        rv[CFG_HIT_BIT]         = q.hit_en;
        rv[CFG_EDO_BIT]         = q.edo;
      end
      else if (haddr_i[7:0] == STATUS_OFFSET)
      begin
        rv[STAT_BUSY_BIT]    = (q.st != ST_IDLE);
        rv[STAT_RASHELD_BIT] = q.ras_held;
        rv[STAT_REFPEND_BIT] = q.refr_pend;
      end
      if (!hwrite_i)
      begin
        n.hrdata = rv;
      end
    end

    unique case (q.st)
      ST_IDLE:
      begin
        n.cnt = 3'h0;
        if (q.refr_pend)
        begin
          if (q.ras_held)
          begin
            n.ras_held = 1'b0;
            n.cnt      = q.rpre;
            n.st       = ST_PRECH;
          end
          else
          begin
            n.st = ST_REF_CAS;
          end
        end
        else if (req_i)
        begin
          n.addr  = addr_i;
          n.is_wr = req_write_i;
          if (req_sram_i)
          begin
            n.st = req_write_i ? ST_S_WACC : ST_S_RACC;
          end
          else if (q.ras_held)
          begin
            n.ras_held = 1'b0;
            n.cnt      = q.rpre;
            n.st       = q.hit_en ? ST_HIT_CMP : ST_PRECH;
          end
          else
          begin
            n.st = ST_D_ROW;
          end
        end
      end
      ST_S_RACC, ST_S_RDATA:
      begin
        if (q.st == ST_S_RDATA)
        begin
          n.rd0      = sram_dq_i;
          n.vpipe[0] = 1'b1;
          n.addr     = q.addr + 1'b1;
        end
        if (q.st == ST_S_RDATA && end_of_block_word_i)
        begin
          n.st = ST_IDLE;
        end
        else if (q.sram_wait_count == 2'h0)
        begin
          n.st = ST_S_RDATA;
        end
        else
        begin
          n.cnt = {1'b0, q.sram_wait_count - 2'h1};
          n.st  = ST_S_RWAIT;
        end
      end
      ST_S_RWAIT:
      begin
        if (q.cnt == 3'h0)
        begin
          n.st = ST_S_RDATA;
        end
        else
        begin
          n.cnt = q.cnt - 3'h1;
        end
      end
      ST_S_WACC:
      begin
        n.st = ST_S_WDATA;
      end
      ST_S_WDATA, ST_D_WDATA:
      begin
        if (wvalid_i)
        begin
          n.wd   = wdata_i;
          n.last = end_of_block_word_i;
          n.cnt  = WR_PULSE_CYC - 3'h1;
          n.st   = (q.st == ST_S_WDATA) ? ST_S_WPULSE : ST_D_WPULSE;
        end
      end
      ST_S_WPULSE, ST_D_WPULSE:
      begin
        if (q.cnt == 3'h0)
        begin
          n.addr = q.addr + 1'b1;
          if (q.st == ST_S_WPULSE)
          begin
            n.done = q.last;
            n.st   = q.last ? ST_IDLE : ST_S_WDATA;
          end
          else
          begin
            n.cnt = WR_RELEASE_CYC - 3'h1;
            n.st  = q.last ? ST_D_WEND : ST_D_WDATA;
          end
        end
        else
        begin
          n.cnt = q.cnt - 3'h1;
        end
      end
      ST_D_ROW:
      begin
        n.row = q.addr[ROW_LSB +: DADDR_W];
        n.cnt = RAS_TO_CAS_CYC - 3'h1;
        n.st  = q.is_wr ? ST_D_WRAS : ST_D_RAS;
      end
      ST_D_RAS:
      begin
        if (q.cnt == 3'h0)
        begin
          n.cnt = q.racc;
          n.st  = ST_D_CAS;
        end
        else
        begin
          n.cnt = q.cnt - 3'h1;
        end
      end
      ST_D_CAS:
      begin
        if (q.cnt == 3'h0)
        begin
          if (!q.edo)
          begin
            n.rd0      = dram_dq_i;
            n.vpipe[0] = 1'b1;
            n.last     = end_of_block_word_i;
          end
          n.st = ST_D_CPRE;
        end
        else
        begin
          n.cnt = q.cnt - 3'h1;
        end
      end
      ST_D_CPRE:
      begin
        if (q.edo)
        begin
          n.rd0      = dram_dq_i;
          n.vpipe[0] = 1'b1;
        end
        n.addr = q.addr + 1'b1;
        if (!last_word)
        begin
          n.cnt = {1'b0, q.crd};
          n.st  = ST_D_CAS;
        end
        else if (q.hit_en && !q.refr_pend)
        begin
          n.ras_held = 1'b1;
          n.st       = ST_IDLE;
        end
        else
        begin
          n.cnt = q.rpre;
          n.st  = ST_PRECH;
        end
      end
      ST_D_WRAS:
      begin
        if (q.cnt == 3'h0)
        begin
          n.st = ST_D_WDATA;
        end
        else
        begin
          n.cnt = q.cnt - 3'h1;
        end
      end
      ST_D_WEND:
      begin
        if (q.cnt != 3'h0)
        begin
          n.cnt = q.cnt - 3'h1;
        end
        else if (q.hit_en && !q.refr_pend)
        begin
          n.done     = 1'b1;
          n.ras_held = 1'b1;
          n.st       = ST_IDLE;
        end
        else
        begin
          n.done = 1'b1;
          n.cnt  = q.rpre;
          n.st   = ST_PRECH;
        end
      end
      ST_HIT_CMP:
      begin
        if (!row_match)
        begin
          n.st = ST_PRECH;
        end
        else if (q.is_wr)
        begin
          n.cnt = 3'h0;
          n.st  = ST_D_WRAS;
        end
        else
        begin
          n.cnt = {1'b0, q.crd};
          n.st  = ST_D_CAS;
        end
      end
      ST_PRECH:
      begin
        if (q.cnt == 3'h0)
        begin
          n.st = ST_IDLE;
        end
        else
        begin
          n.cnt = q.cnt - 3'h1;
        end
      end
      ST_REF_CAS:
      begin
        n.refr_pend = 1'b0;
        n.cnt       = q.racc;
        n.st        = ST_REF_RAS;
      end
      ST_REF_RAS:
      begin
        if (q.cnt == 3'h0)
        begin
          n.cnt = q.rpre;
          n.st  = ST_PRECH;
        end
        else
        begin
          n.cnt = q.cnt - 3'h1;
        end
      end
    endcase

    // A tick landing on the clearing cycle must not be lost, so the set comes last.
    if (refr_edge)
    begin
      n.refr_pend = 1'b1;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_q)
  begin
    if (!rst_n_q)
    begin
      q        <= '0;
      q.sram_wait_count  <= SRAM_WAIT_COUNT_RST;
      q.crd    <= CASRD_RST;
      q.racc   <= RASACC_RST;
      q.rpre   <= RASPRE_RST;
      q.hit_en <= HIT_RST;
      q.edo    <= EDO_RST;
    end
    else
    begin
      q <= n;
    end
  end

  // ==========================================================================
  // Outputs
  assign transfer_accept_n_o = !((q.st == ST_S_RACC) || (q.st == ST_S_WACC)
                               || (q.st == ST_D_ROW && !q.is_wr)
                               || (q.st == ST_D_WRAS && q.cnt == 3'h0)
                               || (q.st == ST_HIT_CMP && !q.is_wr && row_match));
  assign read_word_valid_n_o      = ~q.vpipe[1];
  assign rdata_o                  = q.rd1;
  assign address_data_check_bus_o = q.par;
  assign write_block_done_o       = q.done;
  assign sram_addr_o              = q.addr;
  assign sram_oe_n_o              = !((q.st == ST_S_RWAIT) || (q.st == ST_S_RDATA));
  assign sram_we_n_o              = (q.st != ST_S_WPULSE);
  assign sram_dq_o                = q.wd;
  assign sram_dq_oe_n_o           = (q.st != ST_S_WPULSE);
  assign dram_addr_o = ((q.st == ST_D_ROW) || (q.st == ST_D_RAS) || (q.st == ST_D_WRAS))
                       ? q.addr[ROW_LSB +: DADDR_W] : q.addr[DADDR_W-1:0];
  assign ras_n_o = !(q.ras_held || (q.st == ST_D_RAS) || (q.st == ST_D_CAS) || (q.st == ST_D_CPRE)
                     || (q.st == ST_D_WRAS) || (q.st == ST_D_WDATA) || (q.st == ST_D_WPULSE)
                     || (q.st == ST_D_WEND) || (q.st == ST_HIT_CMP) || (q.st == ST_REF_RAS));
  assign cas_n_o = !((q.st == ST_D_CAS) || (q.st == ST_D_WPULSE)
                     || (q.st == ST_REF_CAS) || (q.st == ST_REF_RAS));
  assign dram_we_n_o = !((q.st == ST_D_WPULSE) || (q.st == ST_D_WEND)
                         || (q.st == ST_D_CPRE && q.edo && last_word));
  assign dram_dq_o      = q.wd;
  assign dram_dq_oe_n_o = !((q.st == ST_D_WPULSE) || (q.st == ST_D_WEND));
  assign hreadyout_o    = 1'b1;
  assign hresp_o        = 1'b0;
  assign hrdata_o       = q.hrdata;

  // ==========================================================================
  // Assertions
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_q);

  sequence s_sram_pulse;
    !sram_we_n_o [*2] ##1 sram_we_n_o;
  endsequence

  sequence s_ras_then_cas;
    (!ras_n_o && cas_n_o) [*2] ##1 (!ras_n_o && !cas_n_o);
  endsequence

  a_read_valid_delay: assert property ((q.st == ST_S_RDATA) |-> ##2 !read_word_valid_n_o)
    else $error("read valid not two clocks after latch");
  a_sram_wait_max: assert property ((q.st == ST_S_RACC && q.sram_wait_count == 2'h3)
    |=> (q.st == ST_S_RWAIT) [*3] ##1 (q.st == ST_S_RDATA))
    else $error("three SRAM wait cycles not inserted");
  a_sram_wait_none: assert property ((q.st == ST_S_RACC && q.sram_wait_count == 2'h0) |=> q.st == ST_S_RDATA)
    else $error("zero wait SRAM read delayed");
  a_sram_wr_accept: assert property ((q.st == ST_IDLE && req_i && req_sram_i && req_write_i
    && !q.refr_pend) |=> !transfer_accept_n_o ##1 transfer_accept_n_o)
    else $error("SRAM write accept not one clock after address");
  a_sram_wr_pulse: assert property ((q.st == ST_S_WDATA && wvalid_i) |=> s_sram_pulse)
    else $error("SRAM write strobe not two clocks");
  a_sram_wr_done: assert property ((q.st == ST_S_WPULSE && q.cnt == 3'h0 && q.last)
    |=> write_block_done_o)
    else $error("write done missing after last word");
  a_ras_cas_gap: assert property ((q.st == ST_D_ROW && !q.is_wr) |=> s_ras_then_cas)
    else $error("CAS not two clocks after RAS");
  a_dram_wr_accept: assert property ((q.st == ST_D_ROW && q.is_wr)
    |=> (!ras_n_o && transfer_accept_n_o) ##1 !transfer_accept_n_o)
    else $error("DRAM write accept not one clock after RAS");
  a_dram_wr_pulse: assert property ((q.st == ST_D_WDATA && wvalid_i)
    |=> (!cas_n_o && !dram_we_n_o) [*2] ##1 cas_n_o)
    else $error("DRAM CAS write pulse not two clocks");
  a_cas_precharge: assert property ((q.st == ST_D_CAS && q.cnt == 3'h0) |=> cas_n_o ##1
    (!cas_n_o || q.st != ST_D_CAS))
    else $error("CAS precharge not one clock");
  a_refresh_ends_hold: assert property ((q.st == ST_IDLE && q.refr_pend && q.ras_held)
    |=> ras_n_o && q.st == ST_PRECH)
    else $error("refresh did not end RAS hold");
  a_edo_last_we: assert property ((q.st == ST_D_CPRE && q.edo && last_word) |-> !dram_we_n_o)
    else $error("EDO final read cycle missing write strobe");

endmodule

// *** dv/bmcc_mem_model.sv ***
// Behavioural SRAM and DRAM arrays facing the memory-cycle controller.
// Assumes word addresses below 32; the DRAM row is not stored.
module bmcc_mem_model (
  input  wire logic        clk_i,
  input  wire logic        edo_i,
  input  wire logic [19:0] sa_i,
  input  wire logic        soe_n_i,
  input  wire logic        swe_n_i,
  input  wire logic        sdoe_n_i,
  input  wire logic [31:0] swd_i,
  output logic [31:0]      srd_o,
  input  wire logic [9:0]  da_i,
  input  wire logic        ras_n_i,
  input  wire logic        cas_n_i,
  input  wire logic        dwe_n_i,
  input  wire logic        doe_n_i,
  input  wire logic [31:0] dwd_i,
  output logic [31:0]      drd_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [31:0] smem [32];
  logic [31:0] dmem [32];
  logic [31:0] held_q;
  logic        hold_q = 1'b0;
  // ==========================================================================
  // Storage and extended-out hold
  always @(posedge clk_i)
  begin
    if (!swe_n_i && !sdoe_n_i)
      smem[sa_i[4:0]] <= swd_i;
    if (!ras_n_i && !cas_n_i && !dwe_n_i && !doe_n_i)
      dmem[da_i[4:0]] <= dwd_i;
    if (!cas_n_i)
      held_q <= dmem[da_i[4:0]];
    // Only extended-out parts keep driving after CAS rises, until RAS or WE ends it.
    hold_q <= edo_i && !ras_n_i && dwe_n_i && (hold_q || !cas_n_i);
  end
  // A released bus shows inverted data, so a mistimed latch cannot pass by luck.
  assign srd_o = soe_n_i ? ~smem[sa_i[4:0]] : smem[sa_i[4:0]];
  assign drd_o = !cas_n_i ? dmem[da_i[4:0]] : (hold_q ? held_q : ~held_q);
endmodule

// *** dv/bmcc_ctrl_tb.sv ***
// Self-checking bench for the board memory-cycle controller.
// Assumes the memory model above and a single 100 MHz clock.
module bmcc_ctrl_tb
  import bmcc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_i = 1'b0, rstn_i = 1'b0, req_i = 1'b0, req_write_i = 1'b0, req_sram_i = 1'b0;
  logic wvalid_i = 1'b0, refresh_tick_i = 1'b0, hsel_i = 1'b0, hwrite_i = 1'b0, hready_i;
  logic [19:0] addr_i = 20'h0, last_a = 20'h0, sram_addr_o;
  logic [31:0] wdata_i = 32'h0, haddr_i = 32'h0, hwdata_i = 32'h0, r;
  logic [31:0] sram_dq_i, dram_dq_i, rdata_o, hrdata_o, sram_dq_o, dram_dq_o;
  logic [1:0] htrans_i = 2'h0;
  logic [2:0] hsize_i = 3'h2;
  logic [3:0] address_data_check_bus_o;
  logic [9:0] dram_addr_o;
  logic end_of_block_word_i, transfer_accept_n_o, read_word_valid_n_o, write_block_done_o;
  logic sram_oe_n_o, sram_we_n_o, sram_dq_oe_n_o, ras_n_o, cas_n_o, dram_we_n_o, dram_dq_oe_n_o;
  logic hreadyout_o, hresp_o;
  logic rp = 1'b1, cp = 1'b1, cbr = 1'b0, dn = 1'b0, edo = 1'b0, eob_w = 1'b0;
  logic [35:0] rq [$];
  int cyc = 0, mismatches = 0, cmp_count = 0, vt = -1, lat, vl, v1, vf;

  assign hready_i = hreadyout_o;
  assign end_of_block_word_i = req_write_i ? eob_w
                             : (req_sram_i ? sram_addr_o == last_a : dram_addr_o == last_a[9:0]);

  bmcc_ctrl DUT (.*);

  bmcc_mem_model MEM (.clk_i(clk_i), .edo_i(edo), .sa_i(sram_addr_o), .soe_n_i(sram_oe_n_o),
    .swe_n_i(sram_we_n_o), .sdoe_n_i(sram_dq_oe_n_o), .swd_i(sram_dq_o), .srd_o(sram_dq_i), .da_i(dram_addr_o),
    .ras_n_i(ras_n_o), .cas_n_i(cas_n_o), .dwe_n_i(dram_we_n_o), .doe_n_i(dram_dq_oe_n_o),
    .dwd_i(dram_dq_o), .drd_o(dram_dq_i));

  always #5 clk_i = ~clk_i;

  // ==========================================================================
  // Monitor and timeout
  always @(posedge clk_i)
  begin
    cyc <= cyc + 1;
    rp <= ras_n_o;
    cp <= cas_n_o;
    if (!ras_n_o && rp && !cp)
      cbr <= 1'b1;
    if (write_block_done_o === 1'b1)
      dn <= 1'b1;
    if (read_word_valid_n_o === 1'b0)
    begin
      rq.push_back({address_data_check_bus_o, rdata_o});
      if (vt < 0)
        vt = cyc;
    end
    if (cyc == 20000)
    begin
      mismatches++;
      close_out();
    end
  end

  // ==========================================================================
  // Tasks
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    cmp_count++;
    if (s !== e)
    begin
      mismatches++;
      $display("MISMATCH at %0t: seen %h expected %h", $time, s, e);
    end
  endtask

  task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] d);
    hsel_i <= 1'b1;
    htrans_i <= 2'h2;
    haddr_i <= a;
    hwrite_i <= w;
    do @(posedge clk_i); while (hready_i !== 1'b1);
    htrans_i <= 2'h0;
    hsel_i <= 1'b0;
    hwdata_i <= d;
    do @(posedge clk_i); while (hready_i !== 1'b1);
    r = hrdata_o;
    chk({31'h0, hresp_o}, 32'h0);
  endtask

  task automatic cfg(input logic [31:0] v);
    edo = v[CFG_EDO_BIT];
    ahb(1'b1, {24'h0, CFG_OFFSET}, v);
  endtask

  // Words carry their own address, so a skipped or repeated step shows in the data.
  task automatic xfer(input logic s, input logic w, input logic [19:0] a, input int n);
    int t0;
    logic [31:0] e;
    t0 = cyc;
    vt = -1;
    dn = 1'b0;
    rq.delete();
    req_i <= 1'b1;
    req_write_i <= w;
    req_sram_i <= s;
    addr_i <= a;
    last_a <= a + 20'(n - 1);
    lat = 0;
    do
    begin
      @(posedge clk_i);
      lat++;
    end
    while (transfer_accept_n_o !== 1'b0);
    req_i <= 1'b0;
    for (int k = 0; k < n && w; k++)
    begin
      @(posedge clk_i);
      wvalid_i <= 1'b1;
      wdata_i <= {12'ha5c, a + 20'(k)};
      eob_w <= (k == n - 1);
      @(posedge clk_i);
      wvalid_i <= 1'b0;
      @(posedge clk_i);
    end
    while (w ? !dn : rq.size() < n)
      @(posedge clk_i);
    vl = vt - t0;
    for (int k = 0; k < n && !w; k++)
    begin
      e = {12'ha5c, a + 20'(k)};
      chk(rq[k][31:0], e);
      chk({28'h0, rq[k][35:32]}, {28'h0, ^e[31:24], ^e[23:16], ^e[15:8], ^e[7:0]});
    end
    repeat (2) @(posedge clk_i);
  endtask

  task automatic close_out();
    $display("Comparisons %0d, mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // ==========================================================================
  // Main sequence
  initial
  begin
    repeat (4) @(posedge clk_i);
    rstn_i <= 1'b1;
    repeat (4) @(posedge clk_i);
    ahb(1'b0, {24'h0, CFG_OFFSET}, 32'h0);
    chk(r, 32'h0000_7733);
    ahb(1'b0, {24'h0, STATUS_OFFSET}, 32'h0);
    chk(r, 32'h0);
    ahb(1'b0, 32'h8, 32'h0);
    chk(r, 32'h0);
    cfg(32'h0000_0001);
    xfer(1'b1, 1'b1, 20'h00004, 3);
    chk(32'(lat), 32'h2);
    xfer(1'b1, 1'b0, 20'h00004, 3);
    chk(32'(lat), 32'h2);
    v1 = vl;
    cfg(32'h0000_0003);
    xfer(1'b1, 1'b0, 20'h00005, 1);
    chk(32'(vl - v1), 32'h2);
    cfg(32'h0000_0001);
    xfer(1'b0, 1'b1, 20'h00404, 2);
    chk(32'(lat), 32'h4);
    chk({31'h0, ras_n_o}, 32'h1);
    xfer(1'b0, 1'b0, 20'h00404, 2);
    chk(32'(lat), 32'h2);
    vf = vl;
    cfg(32'h0000_0701);
    xfer(1'b0, 1'b0, 20'h00405, 1);
    chk(32'(vl - vf), 32'h7);
    cfg(32'h0002_0001);
    xfer(1'b0, 1'b0, 20'h00404, 1);
    chk(32'(vl - vf), 32'h1);
    cfg(32'h0001_0001);
    xfer(1'b0, 1'b0, 20'h00404, 2);
    chk({31'h0, ras_n_o}, 32'h0);
    xfer(1'b0, 1'b1, 20'h00404, 2);
    chk(32'(lat), 32'h3);
    xfer(1'b0, 1'b0, 20'h00404, 1);
    chk({31'h0, vl < vf}, 32'h1);
    xfer(1'b0, 1'b1, 20'h00804, 1);
    chk({31'h0, lat > 4}, 32'h1);
    cfg(32'h0001_7701);
    refresh_tick_i <= 1'b1;
    repeat (60) @(posedge clk_i);
    refresh_tick_i <= 1'b0;
    chk({31'h0, ras_n_o}, 32'h1);
    chk({31'h0, cbr}, 32'h1);
    repeat (2) @(posedge clk_i);
    refresh_tick_i <= 1'b1;
    repeat (6) @(posedge clk_i);
    xfer(1'b0, 1'b0, 20'h00804, 1);
    chk({31'h0, lat > 2}, 32'h1);
    close_out();
  end
endmodule
